// file: sba_agent.sv
`timescale 1ns/1ps
module sba_agent #(
    parameter int ISSUE_SPACING = sba_pkg::SBA_ISSUE_SPACING
) (
    // Clock and reset
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST_B,
    // Arbitration pins
    input  wire sba_pkg::sba_bus_in_t  BUS_I,
    output      sba_pkg::sba_bus_out_t BUS_O,
    // Core side
    input  wire sba_pkg::sba_core_in_t CORE_I,
    output      sba_pkg::sba_core_out_t CORE_O
);

    localparam int GAP_MAX = (1 << sba_pkg::SBA_GAP_W) - 1;

    // Spacing must fit the gap counter
    if (ISSUE_SPACING < 1 || ISSUE_SPACING > GAP_MAX + 1) begin : g_bad_spacing
        $error("ISSUE_SPACING out of range");
    end

    localparam logic [sba_pkg::SBA_GAP_W-1:0] GAP_LOAD =
        sba_pkg::SBA_GAP_W'(ISSUE_SPACING - 1);

    sba_pkg::sba_state_t s_r;
    sba_pkg::sba_state_t s_nxt;

    // Identity from observe pins sampled at reset release
    function automatic logic [1:0] decode_identity(input logic [3:1] obs_b);
        logic [1:0] id;
        id = sba_pkg::SBA_ID_NONE;
        if (!obs_b[1]) begin
            id = sba_pkg::SBA_ID_OBS1;
        end else if (!obs_b[2]) begin
            id = sba_pkg::SBA_ID_OBS2;
        end else if (!obs_b[3]) begin
            id = sba_pkg::SBA_ID_OBS3;
        end
        return id;
    endfunction

    // Pin n of own_identity carries the request of own_identity+n
    function automatic logic [3:0] map_requests(input logic [3:0] raw,
                                                input logic [1:0] id);
        logic [3:0] res;
        res = 4'h0;
        for (int n = 0; n < sba_pkg::SBA_NUM_AGENTS; n++) begin
            res[2'(id + 2'(n))] = raw[n];
        end
        return res;
    endfunction

    // First requester after the rotating identity
    function automatic logic [1:0] pick_winner(input logic [3:0] req,
                                               input logic [1:0] rot);
        logic [1:0] win;
        logic       found;
        win   = rot;
        found = 1'b0;
        for (int k = 1; k <= sba_pkg::SBA_NUM_AGENTS; k++) begin
            if (!found && req[2'(rot + 2'(k))]) begin
                win   = 2'(rot + 2'(k));
                found = 1'b1;
            end
        end
        return win;
    endfunction

    logic       owner;
    logic [3:0] others_req;
    logic [3:0] raw_req;
    logic       issue_ok;
    logic       bus_fault;

    always_comb begin
        s_nxt      = s_r;
        owner      = s_r.busy && (s_r.rotating_identity == s_r.own_identity);
        others_req = s_r.req_seen;
        others_req[s_r.own_identity] = 1'b0;
        raw_req    = ~{BUS_I.observe_pin_b, BUS_I.own_request_pin_b};
        bus_fault  = !BUS_I.address_error_line_b || !BUS_I.bus_initialization_line_b;

        // First edge after release catches the straps; never touched again
        if (!s_r.id_valid) begin
            s_nxt.id_valid     = 1'b1;
            s_nxt.own_identity = decode_identity(BUS_I.observe_pin_b);
        end

        // One registered sample shared by all agents keeps copies equal
        // Strap levels at the capture edge are not requests
        s_nxt.req_seen   = s_r.id_valid ? map_requests(raw_req, s_r.own_identity)
                                        : '0;
        s_nxt.prio_seen  = !BUS_I.priority_request_line_b;
        s_nxt.stall_seen = !BUS_I.stall_line_b;

        // Shared arbitration state, identical in every agent
        if (!s_r.busy) begin
            if (|s_r.req_seen) begin
                s_nxt.rotating_identity = pick_winner(s_r.req_seen,
                                                      s_r.rotating_identity);
                s_nxt.busy              = 1'b1;
            end
        end else if (!s_r.req_seen[s_r.rotating_identity]) begin
            if (|s_r.req_seen) begin
                s_nxt.rotating_identity = pick_winner(s_r.req_seen,
                                                      s_r.rotating_identity);
                s_nxt.busy              = 1'b1;
            end else begin
                s_nxt.busy = 1'b0;
            end
        end

        // Park while nobody else wants the bus; a lock never lets go
        s_nxt.req_drive = s_r.id_valid && (CORE_I.txn_pending || s_r.lock_active
                          || (owner && !(|others_req)));

        // Locked work bypasses the priority agent, never the stall line
        issue_ok = owner && CORE_I.txn_pending && !s_r.stall_seen
                   && (!s_r.prio_seen || s_r.lock_active)
                   && (s_r.gap == '0) && !s_r.txn_issue;
        s_nxt.txn_issue = issue_ok;
        if (issue_ok) begin
            s_nxt.gap = GAP_LOAD;
        end else if (s_r.gap != '0) begin
            s_nxt.gap = s_r.gap - 1'b1;
        end

        if (!CORE_I.txn_locked) begin
            s_nxt.lock_active = 1'b0;
        end else if (issue_ok) begin
            s_nxt.lock_active = 1'b1;
        end

        s_nxt.stall_drive = s_r.id_valid && CORE_I.stall_req;

        // Fault drops ownership and every drive; bus init also rewinds priority
        if (bus_fault) begin
            s_nxt.busy        = 1'b0;
            // Requests seen at the fault edge are dropped so no stale win follows
            s_nxt.req_seen    = '0;
            s_nxt.req_drive   = 1'b0;
            s_nxt.lock_active = 1'b0;
            s_nxt.stall_drive = 1'b0;
            s_nxt.txn_issue   = 1'b0;
            s_nxt.gap         = '0;
            if (!BUS_I.bus_initialization_line_b) begin
                s_nxt.rotating_identity = sba_pkg::SBA_ROT_RESET;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_r                   <= '0;
            s_r.rotating_identity <= sba_pkg::SBA_ROT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Own pin floats until the identity is taken so the central agent can strap it
    always_comb begin
        BUS_O.own_request_pin_b_o = !s_r.req_drive;
        BUS_O.own_request_pin_oe  = s_r.id_valid;
        BUS_O.lock_line_b_o       = !s_r.lock_active;
        BUS_O.lock_line_oe        = s_r.lock_active;
        BUS_O.stall_line_b_o      = !s_r.stall_drive;
        BUS_O.stall_line_oe       = s_r.stall_drive;
    end

    always_comb begin
        CORE_O.txn_issue         = s_r.txn_issue;
        CORE_O.owner             = s_r.busy && (s_r.rotating_identity == s_r.own_identity);
        CORE_O.busy              = s_r.busy;
        CORE_O.id_valid          = s_r.id_valid;
        CORE_O.own_identity      = s_r.own_identity;
        CORE_O.rotating_identity = s_r.rotating_identity;
        CORE_O.lock_active       = s_r.lock_active;
    end

endmodule // sba_agent

// file: sba_peer.sv
`timescale 1ns/1ps
module sba_peer (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // Bench commands, active high
    input  wire logic [1:0]            dut_id,
    input  wire logic [3:0]            req,
    input  wire logic                  prio,
    input  wire logic                  stall,
    input  wire logic                  address_error_line,
    input  wire logic                  bus_initialization_line,
    // Wire levels
    input  wire sba_pkg::sba_bus_out_t dut_o,
    output      sba_pkg::sba_bus_in_t  bus
);
    logic       hold_r;
    logic [3:0] line;
    // Straps stay up through the capture edge after release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            hold_r <= 1'b1;
        else
            hold_r <= 1'b0;
    end
    // Pull-ups give the idle high level on every released line
    always_comb begin
        line = hold_r ? 4'h1 : req;
        line[dut_id] = !hold_r && dut_o.own_request_pin_oe && !dut_o.own_request_pin_b_o;
        bus.own_request_pin_b = !line[dut_id];
        for (int n = 1; n < 4; n++) bus.observe_pin_b[n] = !line[dut_id + 2'(n)];
        bus.priority_request_line_b = !(prio && !hold_r);
        bus.lock_line_b = !(dut_o.lock_line_oe && !dut_o.lock_line_b_o);
        bus.stall_line_b = !(stall && !hold_r)
            && !(dut_o.stall_line_oe && !dut_o.stall_line_b_o);
        bus.address_error_line_b = !address_error_line;
        bus.bus_initialization_line_b = !bus_initialization_line;
    end
endmodule // sba_peer

// file: sba_pkg.sv
// Notes on behaviour
// - Request phase only while holding ownership
// - Identity zero to three, unique per agent
// - Circular priority order 0,1,2,3 then wrap
// - Keep own identity, rotating identity, busy bit
// - Rotating identity marks next lowest priority
// - Reset loads rotating identity with three
// - Winner identity loads rotating identity
// - Priority request blocks new unlocked requests
// - Locked sequence keeps bus until finished
// - Owner drives lock line during locked sequence
// - Stall line stops owner issuing transactions
// - Drive own request pin, observe three others
// - Identity decoded from observe pins at reset
// - Identity fixed until next reset
// - Idle after address error, bus init, reset
// - Idle grant two clocks, busy four minimum; code hands over from busy with no four-clock minimum
// - Owner may park without pending transaction
// - Busy on win, stays busy while owned
// - All arbitration lines deasserted during reset
package sba_pkg;

    localparam int        SBA_NUM_AGENTS    = 4;
    localparam logic [1:0] SBA_ROT_RESET    = 2'h3;
    localparam logic [1:0] SBA_ID_OBS1      = 2'h3;
    localparam logic [1:0] SBA_ID_OBS2      = 2'h2;
    localparam logic [1:0] SBA_ID_OBS3      = 2'h1;
    localparam logic [1:0] SBA_ID_NONE      = 2'h0;
    localparam int        SBA_ISSUE_SPACING = 3;
    localparam int        SBA_GAP_W         = 4;

    // Bus pins, all active low as on the wire
    typedef struct packed {
        logic       own_request_pin_b;
        logic [3:1] observe_pin_b;
        logic       priority_request_line_b;
        logic       lock_line_b;
        logic       stall_line_b;
        logic       address_error_line_b;
        logic       bus_initialization_line_b;
    } sba_bus_in_t;

    typedef struct packed {
        logic own_request_pin_b_o;
        logic own_request_pin_oe;
        logic lock_line_b_o;
        logic lock_line_oe;
        logic stall_line_b_o;
        logic stall_line_oe;
    } sba_bus_out_t;

    // Core side
    typedef struct packed {
        logic txn_pending;
        logic txn_locked;
        logic stall_req;
    } sba_core_in_t;

    typedef struct packed {
        logic       txn_issue;
        logic       owner;
        logic       busy;
        logic       id_valid;
        logic [1:0] own_identity;
        logic [1:0] rotating_identity;
        logic       lock_active;
    } sba_core_out_t;

    // Whole agent state
    typedef struct packed {
        logic                 id_valid;
        logic [1:0]           own_identity;
        logic [1:0]           rotating_identity;
        logic                 busy;
        logic [3:0]           req_seen;
        logic                 prio_seen;
        logic                 stall_seen;
        logic                 req_drive;
        logic                 lock_active;
        logic                 stall_drive;
        logic                 txn_issue;
        logic [SBA_GAP_W-1:0] gap;
    } sba_state_t;

endpackage

// file: sba_properties.sv
`timescale 1ns/1ps
module sba_props (
    // Clock and reset
    input wire logic                   CORE_CLK,
    input wire logic                   RST_B,
    // Watched ports
    input wire sba_pkg::sba_bus_in_t   BUS_I,
    input wire sba_pkg::sba_bus_out_t  BUS_O,
    input wire sba_pkg::sba_core_in_t  CORE_I,
    input wire sba_pkg::sba_core_out_t CORE_O
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    property p_issue; CORE_O.txn_issue |-> $past(CORE_O.owner); endproperty
    a_issue: assert property (p_issue) else $error("issue while not owner");
    property p_owner;
        CORE_O.owner |-> CORE_O.busy && !$past(BUS_I.own_request_pin_b, 2);
    endproperty
    a_owner: assert property (p_owner) else $error("owner state mismatch");
    property p_id; CORE_O.id_valid && $past(CORE_O.id_valid) |-> $stable(CORE_O.own_identity);
    endproperty
    a_id: assert property (p_id) else $error("identity changed");
    property p_init;
        !CORE_O.id_valid |-> CORE_O.rotating_identity == 2'h3 && !CORE_O.busy
            && !BUS_O.own_request_pin_oe;
    endproperty
    a_init: assert property (p_init) else $error("bad state after reset");
    property p_stall; !BUS_I.stall_line_b |-> ##2 !CORE_O.txn_issue; endproperty
    a_stall: assert property (p_stall) else $error("issue during stall");
    property p_prio;
        !BUS_I.priority_request_line_b ##1 !CORE_O.lock_active |=> !CORE_O.txn_issue;
    endproperty
    a_prio: assert property (p_prio) else $error("issue under priority");
    property p_lock;
        CORE_O.lock_active |-> BUS_O.lock_line_oe && !BUS_O.lock_line_b_o
            && BUS_O.own_request_pin_oe && !BUS_O.own_request_pin_b_o;
    endproperty
    a_lock: assert property (p_lock) else $error("lock not held");
    property p_address_error_line; !BUS_I.address_error_line_b |=> !CORE_O.busy && !CORE_O.owner; endproperty
    a_address_error_line: assert property (p_address_error_line) else $error("busy after error");
    property p_bus_initialization_line;
        !BUS_I.bus_initialization_line_b |=> !CORE_O.busy && CORE_O.rotating_identity == 2'h3;
    endproperty
    a_bus_initialization_line: assert property (p_bus_initialization_line) else $error("bad state after init");
    property p_idle;
        !CORE_O.busy && BUS_I.own_request_pin_b && BUS_I.observe_pin_b == 3'h3
            && $past(BUS_I.observe_pin_b[3]) |=> ##1 CORE_O.busy
            && CORE_O.rotating_identity == CORE_O.own_identity + 2'h3;
    endproperty
    a_idle: assert property (p_idle) else $error("idle grant late");
endmodule // sba_props

bind sba_agent sba_props u_props (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .BUS_I(BUS_I),
    .BUS_O(BUS_O), .CORE_I(CORE_I), .CORE_O(CORE_O));

// file: symmetric_bus_arbitration_test.sv
`timescale 1ns/1ps
module symmetric_bus_arbitration_test;
    logic                   clk = 1'b0;
    logic                   rst_b = 1'b0;
    logic [1:0]             id = 2'h0;
    logic [3:0]             req = 4'h0;
    logic [3:0]             m;
    logic                   prio = 1'b0;
    logic                   stall = 1'b0;
    logic                   address_error_line = 1'b0;
    logic                   bus_initialization_line = 1'b0;
    logic [15:0]            seed = 16'h6aff;
    int                     err_total = 0;
    int                     checked = 0;
    int                     rot;
    int                     w;
    int                     n;
    sba_pkg::sba_core_in_t  core_i = '0;
    sba_pkg::sba_bus_in_t   bus_i;
    sba_pkg::sba_bus_out_t  bus_o;
    sba_pkg::sba_core_out_t core_o;

    always #50 clk = ~clk;
    sba_agent u_dut (.CORE_CLK(clk), .RST_B(rst_b), .BUS_I(bus_i), .BUS_O(bus_o),
        .CORE_I(core_i), .CORE_O(core_o));
    sba_peer u_peer (.clk(clk), .rst_b(rst_b), .dut_id(id), .req(req), .prio(prio),
        .stall(stall), .address_error_line(address_error_line), .bus_initialization_line(bus_initialization_line), .dut_o(bus_o), .bus(bus_i));

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #10;
    endtask
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // First requester after the rotating identity in circular order
    function automatic int winner(input int r, input logic [3:0] q);
        for (int i = 1; i < 5; i++) if (q[(r + i) % 4]) return (r + i) % 4;
        return r;
    endfunction

    initial begin
        for (int i = 0; i < 4; i++) begin
            rst_b = 1'b0;
            id = 2'(i);
            tick(4);
            rst_b = 1'b1;
            tick(2);
            check("identity", 4'(core_o.own_identity), 4'(i));
            check("id valid", 4'(core_o.id_valid), 4'h1);
            check("rotating", 4'(core_o.rotating_identity), 4'h3);
        end
        $display("identity test done");
        rot = 3;
        for (int k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            core_i = '0;
            {req, prio, stall} = '0;
            address_error_line = 1'b1;
            tick(1);
            address_error_line = 1'b0;
            tick(2);
            check("busy", 4'(core_o.busy), 4'h0);
            // First pass: a lone request from the agent just before us
            m = (k == 0) ? 4'h4 : seed[3:0];
            core_i.txn_pending = m[3];
            core_i.stall_req = seed[4];
            prio = seed[5];
            stall = seed[6];
            tick(1);
            req = m;
            tick(2);
            w = winner(rot, m);
            if (m != 0) rot = w;
            check("busy", 4'(core_o.busy), 4'(m != 0));
            check("rotating", 4'(core_o.rotating_identity), 4'(rot));
            check("owner", 4'(core_o.owner), 4'(m != 0 && w == 3));
            tick(1);
            check("issue", 4'(core_o.txn_issue),
                4'(m != 0 && w == 3 && seed[6:4] == 3'h0));
            check("stall line", 4'(bus_i.stall_line_b), 4'(!(seed[6] || seed[4])));
            check("request pin", 4'(bus_i.own_request_pin_b), 4'(!m[3]));
        end
        $display("arbitration test done");
        {req, prio, stall} = '0;
        core_i = '0;
        core_i.txn_pending = 1'b1;
        core_i.txn_locked = 1'b1;
        for (n = 0; n < 16 && core_o.txn_issue !== 1'b1; n++) tick(1);
        prio = 1'b1;
        tick(1);
        check("lock", 4'(core_o.lock_active), 4'h1);
        check("lock line", 4'(bus_i.lock_line_b), 4'h0);
        for (n = 0; n < 8 && core_o.txn_issue !== 1'b1; n++) tick(1);
        check("locked issue", 4'(core_o.txn_issue), 4'h1);
        core_i.txn_locked = 1'b0;
        tick(3);
        check("lock", 4'(core_o.lock_active), 4'h0);
        n = 0;
        repeat (8) begin
            tick(1);
            if (core_o.txn_issue !== 1'b0) n++;
        end
        check("blocked issues", 4'(n), 4'h0);
        prio = 1'b0;
        for (n = 0; n < 8 && core_o.txn_issue !== 1'b1; n++) tick(1);
        check("parked issue", 4'(core_o.txn_issue), 4'h1);
        core_i = '0;
        bus_initialization_line = 1'b1;
        tick(1);
        bus_initialization_line = 1'b0;
        check("rotating", 4'(core_o.rotating_identity), 4'h3);
        check("busy", 4'(core_o.busy), 4'h0);
        check("identity", 4'(core_o.own_identity), 4'h3);
        $display("lock test done");
        print_verdict;
    end
    initial begin
        #100000;
        err_total++;
        print_verdict;
    end
endmodule // symmetric_bus_arbitration_test
